// >>> src/iq2_pkg.sv
// Purpose: Constants and carriers for the second interrupt status bank.
// Assumes: 16-bit register port, one register per 16-bit address.
// Notes:   Raw status inputs travel together as one packed struct.
package iq2_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  // Register addresses
  localparam logic [15:0] ADDR_MEM_IF_BLOCK_FLAGS   = 16'h191f;
  localparam logic [15:0] ADDR_MASK_FIRST           = 16'h1940;
  localparam logic [15:0] ADDR_MASK_LAST            = 16'h195f;
  localparam logic [15:0] ADDR_RAW_BOOT_CTRL        = 16'h1980;
  localparam logic [15:0] ADDR_RAW_LOOP_LOCK        = 16'h1981;
  localparam logic [15:0] ADDR_RAW_JACK_MIC         = 16'h1986;
  localparam logic [15:0] ADDR_RAW_RATE_CONV_LOCK   = 16'h1988;
  localparam logic [15:0] ADDR_RAW_SHORT_CIRCUIT    = 16'h198b;
  localparam logic [15:0] ADDR_RAW_OUTPUT_ENABLE    = 16'h198c;
  localparam logic [15:0] ADDR_RAW_OUTPUT_DISABLE   = 16'h198d;
  localparam logic [15:0] ADDR_RAW_SPEAKER_THERMAL  = 16'h198e;
  localparam logic [15:0] ADDR_PIN_LEVEL_LOW        = 16'h1990;
  localparam logic [15:0] ADDR_PIN_LEVEL_MID        = 16'h1991;
  localparam logic [15:0] ADDR_PIN_LEVEL_HIGH       = 16'h1992;
  localparam logic [15:0] ADDR_EVENT_FIFO_NONEMPTY  = 16'h1995;
  localparam logic [15:0] ADDR_EVENT_FIFO_FULL      = 16'h1996;
  localparam logic [15:0] ADDR_EVENT_FIFO_WATERMARK = 16'h1997;
  localparam logic [15:0] ADDR_DSP_DMA_STATE        = 16'h1998;
  localparam logic [15:0] ADDR_DSP_BUSY_STATE       = 16'h199d;
  localparam logic [15:0] ADDR_IRQ_OUT1_CONTROL     = 16'h1a80;
  localparam logic [15:0] ADDR_IRQ_OUT2_CONTROL     = 16'h1a82;
  localparam logic [15:0] ADDR_IRQ_OUT_STATE        = 16'h1aa0;

  // Field positions
  localparam int unsigned MASK_COUNT       = 32;
  localparam logic [4:0]  MASK_IDX_MEM_IF  = 5'h1f;
  localparam int unsigned MEM_IF_COUNT     = 3;
  localparam int unsigned BIT_BOOT_DONE    = 7;
  localparam int unsigned BIT_CTRL_ERR     = 12;
  localparam int unsigned BIT_LOCK_LO      = 8;
  localparam int unsigned BIT_JACK1        = 0;
  localparam int unsigned BIT_JACK2        = 2;
  localparam int unsigned BIT_MIC_CLAMP    = 4;
  localparam int unsigned BIT_OUT_POLARITY = 10;
  localparam int unsigned BIT_OUT_BLOCK    = 11;
  localparam int unsigned BIT_OUT1_STATE   = 0;
  localparam int unsigned BIT_OUT2_STATE   = 1;

  // Reset values
  localparam logic [15:0] MASK_RESET         = 16'hffff;
  localparam logic        OUT1_BLOCK_RESET   = 1'b0;
  localparam logic        OUT2_BLOCK_RESET   = 1'b0;
  localparam logic        OUT_POLARITY_RESET = 1'b1;
  localparam logic [15:0] READ_ZERO          = 16'h0000;

  typedef struct packed {
    logic        ctrl_port_error_state;
    logic        boot_complete_state;
    logic [2:0]  freq_locked_loop_lock;
    logic        mic_clamp_state;
    logic [1:0]  jack_pin_level;
    logic [1:0]  range_ctrl_signal_state;
    logic [3:0]  rate_conv_lock;
    logic [7:0]  out_short_state;
    logic [7:0]  out_on_done;
    logic [7:0]  out_off_done;
    logic        spk_hot_warning;
    logic        spk_hot_limit;
    logic        spk_off_done;
    logic [39:0] pin_level;
    logic [7:0]  log_fifo_has_entries;
    logic [7:0]  log_fifo_is_full;
    logic [7:0]  log_fifo_level_reached;
    logic [6:0]  core_transfer_state;
    logic [6:0]  core_activity_state;
  } iq2_raw_s;

  localparam int unsigned RAW_W = $bits(iq2_raw_s);

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } iq2_req_s;

endpackage : iq2_pkg

// >>> src/iq2_status_ctrl.sv
// Purpose: Second interrupt bank: block flags, masks, raw status, outputs.
// Assumes: Single clk; raw status sources may be asynchronous to clk.
// Notes:   Read data is registered and appears one cycle after rd.
`timescale 1ns/10ps
module iq2_status_ctrl
  import iq2_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire iq2_req_s             reg_req,
  output logic [DATA_W-1:0]         reg_rdata,
  output logic                      reg_rvalid,
  input  wire logic [MEM_IF_COUNT-1:0] mem_if_block_event,
  input  wire iq2_raw_s             raw_in,
  input  wire logic                 out1_combined_state,
  output logic                      out2_combined_state,
  output logic                      irq1_pin,
  output logic                      irq2_pin
);

  logic                    rst_meta_reg;
  logic                    rst_n_sync;
  logic [RAW_W-1:0]        raw_s1_reg;
  logic [RAW_W-1:0]        raw_s2_reg;
  logic [RAW_W-1:0]        raw_s3_reg;
  logic [RAW_W-1:0]        raw_stable_reg;
  iq2_raw_s                raw;
  logic [MEM_IF_COUNT-1:0] event_prev_reg;
  logic [MEM_IF_COUNT-1:0] block_flag_reg;
  logic [MEM_IF_COUNT-1:0] block_flag_next;
  logic [DATA_W-1:0]       mask_reg [MASK_COUNT];
  logic                    out1_block_reg;
  logic                    out2_block_reg;
  logic                    out_polarity_reg;
  logic                    in_mask_range;
  logic [4:0]              mask_idx;
  logic                    wr_flags;
  logic [DATA_W-1:0]       rdata_next;
  logic                    out1_asserted;
  logic                    out2_asserted;

  // Reset released through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  // Three-stage capture; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      raw_s1_reg     <= '0;
      raw_s2_reg     <= '0;
      raw_s3_reg     <= '0;
      raw_stable_reg <= '0;
    end else begin
      raw_s1_reg <= raw_in;
      raw_s2_reg <= raw_s1_reg;
      raw_s3_reg <= raw_s2_reg;
      raw_stable_reg <= (raw_s2_reg & raw_s3_reg)
                      | (raw_stable_reg & (raw_s2_reg ^ raw_s3_reg));
    end
  end

  assign raw = iq2_raw_s'(raw_stable_reg);

  // Register port decode
  assign in_mask_range = (reg_req.addr >= ADDR_MASK_FIRST)
                       && (reg_req.addr <= ADDR_MASK_LAST);
  assign mask_idx      = reg_req.addr[4:0];
  assign wr_flags      = reg_req.wr
                       && (reg_req.addr == ADDR_MEM_IF_BLOCK_FLAGS);

  // Same-clock event sources need no capture stages
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      event_prev_reg <= '0;
    end else begin
      event_prev_reg <= mem_if_block_event;
    end
  end

  // A new edge in the clearing cycle keeps the flag set
  always_comb begin
    block_flag_next = block_flag_reg;
    if (wr_flags) begin
      block_flag_next = block_flag_reg
                      & ~reg_req.wdata[MEM_IF_COUNT-1:0];
    end
    block_flag_next = block_flag_next
                    | (mem_if_block_event & ~event_prev_reg);
  end

  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      block_flag_reg <= '0;
    end else begin
      block_flag_reg <= block_flag_next;
    end
  end

  // Mask bank; unused entries still hold their value for software
  genvar gi;
  generate
    for (gi = 0; gi < MASK_COUNT; gi++) begin : g_mask
      always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
          mask_reg[gi] <= MASK_RESET;
        end else if (reg_req.wr && in_mask_range
                     && (mask_idx == 5'(gi))) begin
          mask_reg[gi] <= reg_req.wdata;
        end
      end
    end
  endgenerate

  // Output control registers
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      out1_block_reg   <= OUT1_BLOCK_RESET;
      out_polarity_reg <= OUT_POLARITY_RESET;
    end else if (reg_req.wr && (reg_req.addr == ADDR_IRQ_OUT1_CONTROL)) begin
      out1_block_reg   <= reg_req.wdata[BIT_OUT_BLOCK];
      out_polarity_reg <= reg_req.wdata[BIT_OUT_POLARITY];
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      out2_block_reg <= OUT2_BLOCK_RESET;
    end else if (reg_req.wr && (reg_req.addr == ADDR_IRQ_OUT2_CONTROL)) begin
      out2_block_reg <= reg_req.wdata[BIT_OUT_BLOCK];
    end
  end

  // Combined state of the bank
  assign out2_combined_state = |(block_flag_reg
      & ~mask_reg[MASK_IDX_MEM_IF][MEM_IF_COUNT-1:0]);

  assign out1_asserted = out1_combined_state && !out1_block_reg;
  assign out2_asserted = out2_combined_state && !out2_block_reg;

  // Pins registered so they never glitch while the mask is rewritten
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      irq1_pin <= OUT_POLARITY_RESET;
      irq2_pin <= OUT_POLARITY_RESET;
    end else begin
      irq1_pin <= out1_asserted ^ out_polarity_reg;
      irq2_pin <= out2_asserted ^ out_polarity_reg;
    end
  end

  // Read mux; unmapped and reserved bits read zero
  always_comb begin
    rdata_next = READ_ZERO;
    case (reg_req.addr)
      ADDR_MEM_IF_BLOCK_FLAGS: begin
        rdata_next[MEM_IF_COUNT-1:0] = block_flag_reg;
      end
      ADDR_RAW_BOOT_CTRL: begin
        rdata_next[BIT_CTRL_ERR]  = raw.ctrl_port_error_state;
        rdata_next[BIT_BOOT_DONE] = raw.boot_complete_state;
      end
      ADDR_RAW_LOOP_LOCK: begin
        rdata_next[BIT_LOCK_LO+:3] = raw.freq_locked_loop_lock;
      end
      ADDR_RAW_JACK_MIC: begin
        rdata_next[BIT_JACK1]     = !raw.jack_pin_level[0];
        rdata_next[BIT_JACK2]     = !raw.jack_pin_level[1];
        rdata_next[BIT_MIC_CLAMP] = raw.mic_clamp_state;
      end
      ADDR_RAW_RATE_CONV_LOCK: begin
        rdata_next[BIT_LOCK_LO+:4] = raw.rate_conv_lock;
        rdata_next[1:0]            = raw.range_ctrl_signal_state;
      end
      ADDR_RAW_SHORT_CIRCUIT: begin
        rdata_next[7:0] = raw.out_short_state;
      end
      ADDR_RAW_OUTPUT_ENABLE: begin
        rdata_next[7:0] = raw.out_on_done;
      end
      ADDR_RAW_OUTPUT_DISABLE: begin
        rdata_next[7:0] = raw.out_off_done;
      end
      ADDR_RAW_SPEAKER_THERMAL: begin
        rdata_next[2:0] = {raw.spk_hot_warning, raw.spk_hot_limit,
                           raw.spk_off_done};
      end
      ADDR_PIN_LEVEL_LOW: begin
        rdata_next = raw.pin_level[15:0];
      end
      ADDR_PIN_LEVEL_MID: begin
        rdata_next = raw.pin_level[31:16];
      end
      ADDR_PIN_LEVEL_HIGH: begin
        rdata_next[7:0] = raw.pin_level[39:32];
      end
      ADDR_EVENT_FIFO_NONEMPTY: begin
        rdata_next[7:0] = raw.log_fifo_has_entries;
      end
      ADDR_EVENT_FIFO_FULL: begin
        rdata_next[7:0] = raw.log_fifo_is_full;
      end
      ADDR_EVENT_FIFO_WATERMARK: begin
        rdata_next[7:0] = raw.log_fifo_level_reached;
      end
      ADDR_DSP_DMA_STATE: begin
        rdata_next[6:0] = raw.core_transfer_state;
      end
      ADDR_DSP_BUSY_STATE: begin
        rdata_next[6:0] = raw.core_activity_state;
      end
      ADDR_IRQ_OUT1_CONTROL: begin
        rdata_next[BIT_OUT_BLOCK]    = out1_block_reg;
        rdata_next[BIT_OUT_POLARITY] = out_polarity_reg;
      end
      ADDR_IRQ_OUT2_CONTROL: begin
        rdata_next[BIT_OUT_BLOCK] = out2_block_reg;
      end
      ADDR_IRQ_OUT_STATE: begin
        rdata_next[BIT_OUT1_STATE] = out1_combined_state;
        rdata_next[BIT_OUT2_STATE] = out2_combined_state;
      end
      default: begin
        if (in_mask_range) begin
          rdata_next = mask_reg[mask_idx];
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      reg_rdata  <= READ_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

endmodule : iq2_status_ctrl

// >>> test/iq2_status_props.sv
// Purpose: Port-level checks for the second interrupt status bank.
// Assumes: Raw sources held steady for eight cycles before a read.
// Notes:   Jack pin index 0 is taken as the first jack input.
`timescale 1ns/10ps
module iq2_status_props
  import iq2_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire iq2_req_s                reg_req,
  input wire logic [DATA_W-1:0]       reg_rdata,
  input wire logic                    reg_rvalid,
  input wire logic [MEM_IF_COUNT-1:0] mem_if_block_event,
  input wire iq2_raw_s                raw_in,
  input wire logic                    out1_combined_state,
  input wire logic                    out2_combined_state,
  input wire logic                    irq1_pin,
  input wire logic                    irq2_pin
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_state_rise: assert property (
    $rose(out2_combined_state) |-> $past(reg_req.wr) ||
    |($past(mem_if_block_event) & ~$past(mem_if_block_event, 2)))
    else $error("combined state rose without event or write");
  chk_state_fall: assert property (
    $fell(out2_combined_state) |-> $past(reg_req.wr))
    else $error("combined state fell without a write");
  chk_pin_steady: assert property (
    !reg_req.wr ##1 ($stable(out2_combined_state) && !reg_req.wr)
    |=> $stable(irq2_pin))
    else $error("second pin moved without cause");
  chk_idle_level: assert property (
    !out1_combined_state && !out2_combined_state |=> irq1_pin == irq2_pin)
    else $error("idle pin levels differ");
  chk_masked_reset: assert property (
    $rose(reset_n) |-> !out2_combined_state [*3])
    else $error("combined state set after reset");
  chk_rdata_hold: assert property (
    !$past(reg_req.rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  chk_rvalid_pulse: assert property (
    reg_rvalid == $past(reg_req.rd))
    else $error("read valid not one cycle after read");
  chk_boot_ctrl: assert property (
    $stable(raw_in) [*8] ##0
    (reg_req.rd && reg_req.addr == ADDR_RAW_BOOT_CTRL) |=>
    reg_rdata == {3'h0, $past(raw_in.ctrl_port_error_state), 4'h0,
    $past(raw_in.boot_complete_state), 7'h00})
    else $error("boot and error bits wrong");
  chk_jack_mic: assert property (
    $stable(raw_in) [*8] ##0
    (reg_req.rd && reg_req.addr == ADDR_RAW_JACK_MIC) |=>
    reg_rdata == {11'h000, $past(raw_in.mic_clamp_state), 1'h0,
    ~$past(raw_in.jack_pin_level[1]), 1'h0,
    ~$past(raw_in.jack_pin_level[0])})
    else $error("jack or clamp bits wrong");
endmodule : iq2_status_props

bind iq2_status_ctrl iq2_status_props i_iq2_status_props (
  .clk(clk), .reset_n(reset_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .mem_if_block_event(mem_if_block_event), .raw_in(raw_in),
  .out1_combined_state(out1_combined_state),
  .out2_combined_state(out2_combined_state),
  .irq1_pin(irq1_pin), .irq2_pin(irq2_pin));

// >>> test/iq2_host_model.sv
// Purpose: Host side of the register port, word reads and writes.
// Assumes: One request at a time, launched on a rising edge.
// Notes:   Released address and data are inverted, never left stale.
`timescale 1ns/10ps
module iq2_host_model
  import iq2_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic              reg_rvalid,
  output iq2_req_s               reg_req
);
  logic booted;
  initial begin
    reg_req = '0;
    booted  = 1'b0;
  end
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~a};
    @(posedge clk);
    reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: a};
    #1;
    if (reg_rvalid !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    d = reg_rdata;
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] s;
    while (booted !== 1'b1) begin
      rd(ADDR_RAW_BOOT_CTRL, s);
      booted = s[BIT_BOOT_DONE];
    end
    @(posedge clk);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask : wr
endmodule : iq2_host_model

// >>> test/testbench.sv
// Purpose: Self-checking bench for the second interrupt status bank.
// Assumes: Host model owns the register port; bench drives sources.
// Notes:   Raw reads wait out the input synchroniser first.
`timescale 1ns/10ps
module testbench
  import iq2_pkg::*;
;
  logic                    clk;
  logic                    reset_n;
  logic                    out1_combined_state;
  logic [MEM_IF_COUNT-1:0] mem_if_block_event;
  iq2_raw_s                raw_in;
  iq2_req_s                reg_req;
  logic [DATA_W-1:0]       reg_rdata;
  logic                    reg_rvalid;
  logic                    out2_combined_state;
  logic                    irq1_pin;
  logic                    irq2_pin;
  logic [127:0]            pat;
  int                      fails;
  int                      compares;
  localparam logic [15:0] RAW_ADDR [16] = '{ADDR_RAW_BOOT_CTRL,
    ADDR_RAW_LOOP_LOCK, ADDR_RAW_JACK_MIC, ADDR_RAW_RATE_CONV_LOCK,
    ADDR_RAW_SHORT_CIRCUIT, ADDR_RAW_OUTPUT_ENABLE, ADDR_RAW_OUTPUT_DISABLE,
    ADDR_RAW_SPEAKER_THERMAL, ADDR_PIN_LEVEL_LOW, ADDR_PIN_LEVEL_MID,
    ADDR_PIN_LEVEL_HIGH, ADDR_EVENT_FIFO_NONEMPTY, ADDR_EVENT_FIFO_FULL,
    ADDR_EVENT_FIFO_WATERMARK, ADDR_DSP_DMA_STATE, ADDR_DSP_BUSY_STATE};

  iq2_status_ctrl i_iq2_status_ctrl (.clk(clk), .reset_n(reset_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .mem_if_block_event(mem_if_block_event), .raw_in(raw_in),
    .out1_combined_state(out1_combined_state),
    .out2_combined_state(out2_combined_state),
    .irq1_pin(irq1_pin), .irq2_pin(irq2_pin));
  iq2_host_model i_iq2_host_model (.clk(clk), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_req(reg_req));

  function automatic logic [15:0] exp_raw(input logic [15:0] a,
                                          input iq2_raw_s r);
    case (a)
      16'h1980: return {3'h0, r.ctrl_port_error_state, 4'h0,
                        r.boot_complete_state, 7'h00};
      16'h1981: return {5'h00, r.freq_locked_loop_lock, 8'h00};
      16'h1986: return {11'h000, r.mic_clamp_state, 1'h0,
        ~r.jack_pin_level[1], 1'h0, ~r.jack_pin_level[0]};
      16'h1988: return {4'h0, r.rate_conv_lock, 6'h00,
                        r.range_ctrl_signal_state};
      16'h198b: return {8'h00, r.out_short_state};
      16'h198c: return {8'h00, r.out_on_done};
      16'h198d: return {8'h00, r.out_off_done};
      16'h198e: return {13'h0000, r.spk_hot_warning, r.spk_hot_limit,
                        r.spk_off_done};
      16'h1990: return r.pin_level[15:0];
      16'h1991: return r.pin_level[31:16];
      16'h1992: return {8'h00, r.pin_level[39:32]};
      16'h1995: return {8'h00, r.log_fifo_has_entries};
      16'h1996: return {8'h00, r.log_fifo_is_full};
      16'h1997: return {8'h00, r.log_fifo_level_reached};
      16'h1998: return {9'h000, r.core_transfer_state};
      default:  return {9'h000, r.core_activity_state};
    endcase
  endfunction : exp_raw

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic rchk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    i_iq2_host_model.rd(a, d);
    check(d, e);
  endtask : rchk

  task automatic t_reset_vals;
    check(irq2_pin, 1'b1);
    rchk(ADDR_IRQ_OUT1_CONTROL, 16'h0c00 & 16'h0400);
    rchk(ADDR_IRQ_OUT2_CONTROL, 16'h0000);
    rchk(16'h0000, 16'h0000);
    for (int i = 0; i < MASK_COUNT; i++)
      rchk(ADDR_MASK_FIRST + 16'(i), 16'hffff);
  endtask : t_reset_vals
  // Read-only writes only once boot is seen, since the host holds them
  task automatic t_raw(input iq2_raw_s r, input bit poke);
    @(posedge clk);
    raw_in <= r;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      if (poke)
        i_iq2_host_model.wr(RAW_ADDR[i], ~exp_raw(RAW_ADDR[i], r));
      rchk(RAW_ADDR[i], exp_raw(RAW_ADDR[i], r));
    end
  endtask : t_raw

  task automatic t_flags;
    i_iq2_host_model.wr(ADDR_MASK_LAST, 16'hfff8);
    for (int n = 0; n < MEM_IF_COUNT; n++) begin
      @(posedge clk);
      mem_if_block_event[n] <= 1'b1;
      settle();
      check(irq2_pin, 1'b0);
      check(out2_combined_state, 1'b1);
      rchk(ADDR_MEM_IF_BLOCK_FLAGS, 16'h0001 << n);
      i_iq2_host_model.wr(ADDR_MEM_IF_BLOCK_FLAGS, 16'h0001 << n);
      rchk(ADDR_MEM_IF_BLOCK_FLAGS, 16'h0000);
      check(irq2_pin, 1'b1);
    end
    i_iq2_host_model.wr(ADDR_MASK_LAST, 16'hffff);
    @(posedge clk);
    mem_if_block_event <= 3'h0;
    @(posedge clk);
    mem_if_block_event <= 3'h1;
    settle();
    check(out2_combined_state, 1'b0);
    rchk(ADDR_MEM_IF_BLOCK_FLAGS, 16'h0001);
    i_iq2_host_model.wr(ADDR_MASK_LAST, 16'hfff8);
    settle();
    check(irq2_pin, 1'b0);
    i_iq2_host_model.wr(ADDR_IRQ_OUT2_CONTROL, 16'h0800);
    settle();
    check(irq2_pin, 1'b1);
    i_iq2_host_model.wr(ADDR_IRQ_OUT1_CONTROL, 16'h0000);
    settle();
    check(irq2_pin, 1'b0);
    i_iq2_host_model.wr(ADDR_IRQ_OUT2_CONTROL, 16'h0000);
    settle();
    check(irq2_pin, 1'b1);
    @(posedge clk);
    out1_combined_state <= 1'b1;
    settle();
    check(irq1_pin, 1'b1);
    i_iq2_host_model.wr(ADDR_IRQ_OUT1_CONTROL, 16'h0800);
    settle();
    check(irq1_pin, 1'b0);
    rchk(ADDR_IRQ_OUT1_CONTROL, 16'h0800);
    rchk(ADDR_IRQ_OUT_STATE, 16'h0003);
  endtask : t_flags

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs a few hundred cycles; this leaves ample margin
  initial begin
    #100us;
    fails++;
    finish_test();
  end
  initial begin
    reset_n = 1'b0;
    out1_combined_state = 1'b0;
    mem_if_block_event = 3'h0;
    raw_in = '0;
    pat = {8{16'ha5c3}};
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset_vals();
    t_raw(pat[RAW_W-1:0], 1'b0);
    t_raw(~pat[RAW_W-1:0], 1'b1);
    t_flags();
    finish_test();
  end
endmodule : testbench
